// [csrc_chan.sv]
// One light channel converter: saturating sixteen-bit accumulator.
// Assumes the level input is already on the system clock.
`timescale 1ns/1ps
module csrc_chan
    import csrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] level,
    output logic [15:0] acc
);
    typedef struct packed
    {
        logic [15:0] acc;
    } csrc_chan_t;
    csrc_chan_t state_reg;
    csrc_chan_t state_next;
    logic [16:0] sum;

    always_comb
    begin
        sum = {1'b0, state_reg.acc} + {9'h000, level};
        state_next = state_reg;
        if (clr)
            state_next.acc = 16'h0000;
        else if (en)
            state_next.acc = sum[16] ? 16'hFFFF : sum[15:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign acc = state_reg.acc;
endmodule

// [csrc_host.sv]
// Serial bus master model for the host controller.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module csrc_host
(
    input wire logic clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_drv
);
    // Clock stands high between frames; it only toggles inside them
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b0;
    end
    task automatic put_bit(input logic b, output logic got);
        scl <= 1'b0;
        repeat (2) @(posedge clk);
        sda_drv <= !b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        got = sda_bus;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic last,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(last, ack);
    endtask
    task automatic start();
        repeat (4) @(posedge clk);
        sda_drv <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic stop();
        scl <= 1'b0;
        sda_drv <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic hold_low(input int n);
        scl <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
endmodule

// [csrc_pkg.sv]
// Constants, types and state encodings of the colour sensor readout control.
// Assumes a 50 MHz system clock and an Avalon-MM register bus on that clock.
//
// Summary of operation
// - Serial slave answers at seven-bit address 0111001b, plus 0001100b for alert response reads.
// - Each light channel result is sixteen bits wide.
// - Four independent accumulators convert red, green, blue and clear together.
// - One serial read streams red, green, blue and clear results without extra commands.
// - Software picks the interrupt channel; each channel has own thresholds.
// - Interrupt stays pending until software clears it.
// - Interrupt pin is open drain, pulled low while pending.
// - SMBus variant behaves as alert line; I2C variant as plain level.
// - Sync mode: sync edge starts one internally timed integration.
// - Accumulate mode integrates over a programmed count of sync pulses.
// - Free-running mode and bus-commanded start/stop mode are offered.
// - SMBus variant resets serial logic when clock or data low 25 ms.
package csrc_pkg;
    localparam int CSRC_CLK_HZ = 50_000_000;
    localparam int CSRC_TIMEOUT_MS = 25;
    localparam int CSRC_TIMEOUT_CYC = CSRC_TIMEOUT_MS * (CSRC_CLK_HZ / 1000);
    localparam logic [6:0] CSRC_I2C_ADDR = 7'h39;
    localparam logic [6:0] CSRC_ARA_ADDR = 7'h0C;
    localparam logic [6:0] CSRC_OFS_CTRL = 7'h00;
    localparam logic [6:0] CSRC_OFS_ITIME = 7'h04;
    localparam logic [6:0] CSRC_OFS_PULSES = 7'h08;
    localparam logic [6:0] CSRC_OFS_STATUS = 7'h0C;
    localparam logic [6:0] CSRC_OFS_THR_LO = 7'h10;
    localparam logic [6:0] CSRC_OFS_THR_HI = 7'h20;
    localparam logic [6:0] CSRC_OFS_RESULT = 7'h30;
    localparam logic [15:0] CSRC_ITIME_RST = 16'h0400;
    localparam logic [7:0] CSRC_PULSES_RST = 8'h04;
    localparam logic [15:0] CSRC_THR_LO_RST = 16'h0000;
    localparam logic [15:0] CSRC_THR_HI_RST = 16'hFFFF;
    localparam int CSRC_BIT_EN = 0;
    localparam int CSRC_BIT_RUN = 3;
    localparam int CSRC_BIT_INTEN = 6;
    localparam int CSRC_BIT_SMB = 7;
    localparam int CSRC_CMD_CLR = 0;
    localparam int CSRC_CMD_START = 1;
    localparam int CSRC_CMD_STOP = 2;
    typedef enum logic [1:0]
    {
        CSRC_MODE_FREE = 2'b00,
        CSRC_MODE_BUS = 2'b01,
        CSRC_MODE_SYNC = 2'b10,
        CSRC_MODE_ACCUM = 2'b11
    } csrc_mode_t;
    typedef enum logic [0:0]
    {
        CSRC_INT_IDLE = 1'b0,
        CSRC_INT_RUN = 1'b1
    } csrc_int_t;
    typedef enum logic [2:0]
    {
        CSRC_I_IDLE = 3'b000,
        CSRC_I_ADDR = 3'b001,
        CSRC_I_ACKA = 3'b010,
        CSRC_I_WDATA = 3'b011,
        CSRC_I_ACKW = 3'b100,
        CSRC_I_RDATA = 3'b101,
        CSRC_I_ACKR = 3'b110
    } csrc_i2c_t;
endpackage

// [csrc_sync.sv]
// Two-flop synchroniser with edge detection for one asynchronous pin.
// Assumes the pin changes slower than two clock periods.
`timescale 1ns/1ps
module csrc_sync
    import csrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
    } csrc_sync_t;
    csrc_sync_t state_reg;
    csrc_sync_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.s1 = din;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
    end

    // Resets high so an idle bus line shows no false edge
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
        else
            state_reg <= state_next;
    end

    assign level = state_reg.s2;
    assign rise = state_reg.s2 & ~state_reg.s3;
    assign fall = ~state_reg.s2 & state_reg.s3;
endmodule

// [csrc_top.sv]
// Colour sensor readout control: integration sequencer, result latch,
// threshold interrupt, two-wire serial slave and Avalon-MM registers.
// Assumes scl, sda_in and sync_in are asynchronous pins; Avalon is on clk.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module csrc_top
    import csrc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = CSRC_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sync_in,
    output logic int_out,
    output logic int_oe,
    input wire logic [7:0] light_red,
    input wire logic [7:0] light_green,
    input wire logic [7:0] light_blue,
    input wire logic [7:0] light_clear
);
    typedef struct packed
    {
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [15:0] itime;
        logic [7:0] pulses;
        logic [3:0][15:0] thr_lo;
        logic [3:0][15:0] thr_hi;
        logic [3:0][15:0] res;
        logic pending;
        logic alert_rel;
        logic int_oe;
        csrc_int_t ist;
        logic [15:0] tcnt;
        logic [7:0] pcnt;
        csrc_i2c_t bst;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic ara;
        logic nack;
        logic [2:0] bptr;
        logic sda_oe;
        logic [20:0] tocnt;
    } csrc_top_t;

    csrc_top_t state_reg;
    csrc_top_t state_next;

    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic syn_rise;
    logic conv_clr;
    logic conv_en;
    logic [3:0][7:0] light;
    logic [3:0][15:0] acc;
    logic [31:0] rd_mux;
    logic [7:0] tx_byte;
    logic finish;
    logic [15:0] sel_val;
    logic [1:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and channel converters

    csrc_sync u_scl
    (
        .clk(clk),
        .rst_b(rst_b),
        .din(scl),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    csrc_sync u_sda
    (
        .clk(clk),
        .rst_b(rst_b),
        .din(sda_in),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    csrc_sync u_syn
    (
        .clk(clk),
        .rst_b(rst_b),
        .din(sync_in),
        .level(),
        .rise(syn_rise),
        .fall()
    );

    assign light = {light_clear, light_blue, light_green, light_red};

    // Separate accumulators, so no channel waits for another
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_chan
            csrc_chan u_chan
            (
                .clk(clk),
                .rst_b(rst_b),
                .clr(conv_clr),
                .en(conv_en),
                .level(light[gi]),
                .acc(acc[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        idx = address[3:2];
        sel_val = 16'h0000;
        rd_mux = 32'h0000_0000;
        tx_byte = 8'h00;
        conv_clr = 1'b0;
        finish = 1'b0;
        state_next = state_reg;
        conv_en = state_reg.ist == CSRC_INT_RUN;

        // Register read mux; unmapped offsets read zero
        case (address)
            CSRC_OFS_CTRL: rd_mux = {24'h000000, state_reg.ctrl};
            CSRC_OFS_ITIME: rd_mux = {16'h0000, state_reg.itime};
            CSRC_OFS_PULSES: rd_mux = {24'h000000, state_reg.pulses};
            CSRC_OFS_STATUS: rd_mux = {29'h00000000, state_reg.alert_rel,
                conv_en, state_reg.pending};
            default:
            begin
                if (address[6:4] == CSRC_OFS_THR_LO[6:4] && address[1:0] == 2'b00)
                    rd_mux = {16'h0000, state_reg.thr_lo[idx]};
                else if (address[6:4] == CSRC_OFS_THR_HI[6:4] && address[1:0] == 2'b00)
                    rd_mux = {16'h0000, state_reg.thr_hi[idx]};
                else if (address[6:4] == CSRC_OFS_RESULT[6:4] && address[1:0] == 2'b00)
                    rd_mux = {16'h0000, state_reg.res[idx]};
            end
        endcase

        // Integration sequencer
        if (!state_reg.ctrl[CSRC_BIT_EN])
        begin
            state_next.ist = CSRC_INT_IDLE;
        end
        else
        begin
            case (state_reg.ist)
                CSRC_INT_IDLE:
                begin
                    state_next.tcnt = 16'h0000;
                    state_next.pcnt = 8'h00;
                    case (csrc_mode_t'(state_reg.ctrl[2:1]))
                        CSRC_MODE_FREE: conv_clr = 1'b1;
                        CSRC_MODE_BUS: conv_clr = state_reg.ctrl[CSRC_BIT_RUN];
                        default: conv_clr = syn_rise;
                    endcase
                    if (conv_clr)
                        state_next.ist = CSRC_INT_RUN;
                end
                CSRC_INT_RUN:
                begin
                    state_next.tcnt = state_reg.tcnt + 16'h0001;
                    case (csrc_mode_t'(state_reg.ctrl[2:1]))
                        CSRC_MODE_BUS: finish = !state_reg.ctrl[CSRC_BIT_RUN];
                        CSRC_MODE_ACCUM:
                        begin
                            if (syn_rise)
                            begin
                                state_next.pcnt = state_reg.pcnt + 8'h01;
                                finish = state_reg.pcnt + 8'h01 >= state_reg.pulses;
                            end
                        end
                        default:
                            finish = state_reg.tcnt >= state_reg.itime
                                && state_reg.tcnt != 16'h0000;
                    endcase
                    if (finish)
                        state_next.ist = CSRC_INT_IDLE;
                end
                default: state_next.ist = CSRC_INT_IDLE;
            endcase
        end

        // Latch all channels at once and test the selected one
        sel_val = acc[state_reg.ctrl[5:4]];
        if (finish)
        begin
            state_next.res = acc;
            if (state_reg.ctrl[CSRC_BIT_INTEN] &&
                (sel_val < state_reg.thr_lo[state_reg.ctrl[5:4]] ||
                 sel_val > state_reg.thr_hi[state_reg.ctrl[5:4]]))
                state_next.pending = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // Two-wire serial slave; the host owns the clock
        tx_byte = state_reg.ara ? {CSRC_I2C_ADDR, 1'b0} :
            state_reg.bptr[0] ? state_reg.res[state_reg.bptr[2:1]][15:8] :
            state_reg.res[state_reg.bptr[2:1]][7:0];
        case (state_reg.bst)
            CSRC_I_ADDR:
            begin
                if (scl_rise)
                begin
                    state_next.shreg = {state_reg.shreg[6:0], sda_lvl};
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end
                if (scl_fall && state_reg.bitcnt == 4'h8)
                begin
                    state_next.rw = state_reg.shreg[0];
                    state_next.ara = state_reg.shreg[7:1] == CSRC_ARA_ADDR;
                    if (state_reg.shreg[7:1] == CSRC_I2C_ADDR ||
                        (state_reg.shreg == {CSRC_ARA_ADDR, 1'b1} &&
                         state_reg.ctrl[CSRC_BIT_SMB] && state_reg.int_oe))
                    begin
                        state_next.sda_oe = 1'b1;
                        state_next.bst = CSRC_I_ACKA;
                    end
                    else
                        state_next.bst = CSRC_I_IDLE;
                end
            end
            CSRC_I_ACKA, CSRC_I_ACKW:
            begin
                if (scl_fall)
                begin
                    state_next.bitcnt = 4'h0;
                    state_next.sda_oe = 1'b0;
                    state_next.bst = CSRC_I_WDATA;
                    if (state_reg.bst == CSRC_I_ACKA && state_reg.rw)
                    begin
                        state_next.shreg = tx_byte;
                        state_next.sda_oe = ~tx_byte[7];
                        state_next.bptr = state_reg.bptr + 3'h1;
                        state_next.bst = CSRC_I_RDATA;
                        if (state_reg.ara)
                            state_next.alert_rel = 1'b1;
                    end
                end
            end
            CSRC_I_WDATA:
            begin
                if (scl_rise)
                begin
                    state_next.shreg = {state_reg.shreg[6:0], sda_lvl};
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end
                if (scl_fall && state_reg.bitcnt == 4'h8)
                begin
                    state_next.sda_oe = 1'b1;
                    state_next.bst = CSRC_I_ACKW;
                    if (state_reg.shreg[CSRC_CMD_START])
                        state_next.ctrl[CSRC_BIT_RUN] = 1'b1;
                    if (state_reg.shreg[CSRC_CMD_STOP])
                        state_next.ctrl[CSRC_BIT_RUN] = 1'b0;
                    if (state_reg.shreg[CSRC_CMD_CLR] && !finish)
                        state_next.pending = 1'b0;
                end
            end
            CSRC_I_RDATA:
            begin
                if (scl_rise)
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                if (scl_fall)
                begin
                    if (state_reg.bitcnt == 4'h8)
                    begin
                        state_next.sda_oe = 1'b0;
                        state_next.bst = CSRC_I_ACKR;
                    end
                    else
                    begin
                        state_next.shreg = {state_reg.shreg[6:0], 1'b0};
                        state_next.sda_oe = ~state_reg.shreg[6];
                    end
                end
            end
            CSRC_I_ACKR:
            begin
                if (scl_rise)
                    state_next.nack = sda_lvl;
                if (scl_fall)
                begin
                    state_next.bitcnt = 4'h0;
                    if (state_reg.nack)
                        state_next.bst = CSRC_I_IDLE;
                    else
                    begin
                        state_next.shreg = tx_byte;
                        state_next.sda_oe = ~tx_byte[7];
                        state_next.bptr = state_reg.bptr + 3'h1;
                        state_next.bst = CSRC_I_RDATA;
                    end
                end
            end
            default: state_next.bst = CSRC_I_IDLE;
        endcase

        // Start and stop conditions override the bit engine
        if (scl_lvl && sda_fall)
        begin
            state_next.bst = CSRC_I_ADDR;
            state_next.bitcnt = 4'h0;
            state_next.bptr = 3'h0;
            state_next.sda_oe = 1'b0;
        end
        else if (scl_lvl && sda_rise)
        begin
            state_next.bst = CSRC_I_IDLE;
            state_next.sda_oe = 1'b0;
        end

        // Bus stuck low: counter saturates so the reset is held, not repeated
        if (state_reg.ctrl[CSRC_BIT_SMB] && (!scl_lvl || !sda_lvl))
        begin
            if (state_reg.tocnt != 21'(TIMEOUT_CYC - 1))
                state_next.tocnt = state_reg.tocnt + 21'h000001;
            else
            begin
                state_next.bst = CSRC_I_IDLE;
                state_next.sda_oe = 1'b0;
            end
        end
        else
            state_next.tocnt = 21'h000000;

        ////////////////////////////////////////////////////////////////////
        // Avalon slave: one wait cycle, then a single answer cycle
        state_next.waitreq = 1'b1;
        if ((read || write) && state_reg.waitreq)
        begin
            state_next.waitreq = 1'b0;
            state_next.rdata = rd_mux;
        end
        if (write && !state_reg.waitreq)
        begin
            case (address)
                CSRC_OFS_CTRL: state_next.ctrl = writedata[7:0];
                CSRC_OFS_ITIME: state_next.itime = writedata[15:0];
                CSRC_OFS_PULSES: state_next.pulses = writedata[7:0];
                CSRC_OFS_STATUS:
                begin
                    if (writedata[0] && !finish)
                        state_next.pending = 1'b0;
                end
                default:
                begin
                    if (address[6:4] == CSRC_OFS_THR_LO[6:4] && address[1:0] == 2'b00)
                        state_next.thr_lo[idx] = writedata[15:0];
                    else if (address[6:4] == CSRC_OFS_THR_HI[6:4] && address[1:0] == 2'b00)
                        state_next.thr_hi[idx] = writedata[15:0];
                end
            endcase
        end

        // Released alert re-arms once the pending flag is gone
        if (!state_next.pending)
            state_next.alert_rel = 1'b0;
        state_next.int_oe = state_next.pending &&
            !(state_next.ctrl[CSRC_BIT_SMB] && state_next.alert_rel);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
            state_reg.waitreq <= 1'b1;
            state_reg.itime <= CSRC_ITIME_RST;
            state_reg.pulses <= CSRC_PULSES_RST;
            state_reg.thr_lo <= {4{CSRC_THR_LO_RST}};
            state_reg.thr_hi <= {4{CSRC_THR_HI_RST}};
            state_reg.ist <= CSRC_INT_IDLE;
            state_reg.bst <= CSRC_I_IDLE;
        end
        else
            state_reg <= state_next;
    end

    assign readdata = state_reg.rdata;
    assign waitrequest = state_reg.waitreq;
    assign sda_oe = state_reg.sda_oe;
    assign int_oe = state_reg.int_oe;
    // Open-drain pins only ever pull low; each output is a struct bit ANDed with a constant zero
    assign sda_out = state_reg.alert_rel & 1'b0;
    assign int_out = state_reg.ara & 1'b0;
endmodule

// [csrc_top_sva.sv]
// Port-level checks of the readout control block.
// Assumes binding into csrc_top; one clock domain.
`timescale 1ns/1ps
module csrc_chk
    import csrc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = CSRC_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic int_out,
    input wire logic int_oe
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
////////////////////////////////////////////////////////////////
// Clear window: a serial clear lands a few cycles after SCL activity
logic [3:0] win_reg;
logic [3:0] win_next;
always_comb
begin
    win_next = (win_reg != 4'h0) ? win_reg - 4'h1 : 4'h0;
    if (!scl || (write && !waitrequest && address == CSRC_OFS_STATUS && writedata[0]))
    begin
        win_next = 4'hF;
    end
end
always_ff @(posedge clk)
begin
    win_reg <= rst_b ? win_next : 4'h0;
end
////////////////////////////////////////////////////////////////
AST_WAIT_ANS: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one cycle");
AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("wait low for more than one cycle");
AST_WAIT_RST: assert property ($rose(rst_b) |-> waitrequest && readdata == 32'h0)
    else $error("bus outputs not idle after reset");
AST_RD_HOLD: assert property (waitrequest |-> $stable(readdata))
    else $error("read data moved between answers");
AST_SDA_LOW: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
AST_INT_LOW: assert property (int_out == 1'b0)
    else $error("interrupt pin driven high");
AST_SDA_RISE: assert property ($rose(sda_oe) |-> !scl)
    else $error("data pulled while clock high");
AST_SDA_HOLD: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data changed while clock high");
AST_INT_HOLD: assert property ($fell(int_oe) |-> win_reg != 4'h0)
    else $error("interrupt released without a clear");
endmodule
bind csrc_top csrc_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .scl(scl), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe));

// [csrc_top_test.sv]
// Self-checking bench of the readout control block.
// Assumes csrc_host as serial master; light levels R=1 G=2 B=3 C=4.
`timescale 1ns/1ps
module csrc_top_test
    import csrc_pkg::*;
;
localparam int TO = 200;
localparam int IT = 10;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic [6:0] address = 7'h00;
logic read = 1'b0;
logic write = 1'b0;
logic [31:0] writedata = 32'h0;
logic sync_in = 1'b0;
logic [7:0] lvl [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
logic [31:0] readdata;
logic waitrequest, sda_out, sda_oe, int_out, int_oe, scl, host_sda;
logic [7:0] rx;
logic ack;
logic [31:0] q;
wire sda_bus = !(host_sda || sda_oe);
int err_count = 0;
int num_checks = 0;
////////////////////////////////////////////////////////////////
csrc_top #(.TIMEOUT_CYC(TO)) DUT (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .scl(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .sync_in(sync_in), .int_out(int_out), .int_oe(int_oe),
    .light_red(lvl[0]), .light_green(lvl[1]), .light_blue(lvl[2]), .light_clear(lvl[3]));
csrc_host host (.clk(clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(host_sda));
initial
begin
    forever #10 clk = ~clk;
end
////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    // Wait for the answer; only the watchdog ends a hung wait
    while (waitrequest !== 1'b0)
    begin
        @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
endtask
task automatic pulse(input int gap);
    sync_in <= 1'b1;
    repeat (10) @(posedge clk);
    sync_in <= 1'b0;
    repeat (gap) @(posedge clk);
endtask
task automatic frame(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.byte_io(a, 1'b1, rx, ack);
    if (d != 8'h00) host.byte_io(d, 1'b1, rx, ack);
    host.stop();
endtask
////////////////////////////////////////////////////////////////
task automatic t_reset();
    bus(0, CSRC_OFS_ITIME, 0);
    check("itime", q, {16'h0, CSRC_ITIME_RST});
    bus(0, CSRC_OFS_THR_HI, 0);
    check("thr hi", q, {16'h0, CSRC_THR_HI_RST});
    bus(0, 7'h7C, 0);
    check("unmapped", q, 0);
    check("pins low", {int_out, sda_out}, 0);
endtask
task automatic t_sync();
    bus(1, CSRC_OFS_ITIME, IT);
    bus(1, CSRC_OFS_CTRL, 32'h0000_0005);
    pulse(30);
    for (int i = 0; i < 4; i++)
    begin
        bus(0, CSRC_OFS_RESULT + 7'(4 * i), 0);
        check("result", q, IT * (i + 1));
    end
endtask
task automatic t_serial();
    host.start();
    host.byte_io({CSRC_I2C_ADDR, 1'b1}, 1'b1, rx, ack);
    check("addr ack", ack, 0);
    for (int i = 0; i < 8; i++)
    begin
        host.byte_io(8'hFF, i == 7, rx, ack);
        check("serial byte", rx, (i % 2) ? 0 : IT * (i / 2 + 1));
    end
    host.stop();
    frame(8'h55, 8'h00);
    check("foreign addr", ack, 1);
endtask
task automatic t_irq();
    bus(1, CSRC_OFS_THR_HI + 7'h04, 32'h0000_0005);
    bus(1, CSRC_OFS_CTRL, 32'h0000_0055);
    check("irq idle", int_oe, 0);
    pulse(200);
    check("irq held", int_oe, 1);
    bus(0, CSRC_OFS_STATUS, 0);
    check("pending", q[0], 1);
    frame({CSRC_I2C_ADDR, 1'b0}, 8'h01);
    check("irq cleared", int_oe, 0);
    bus(1, CSRC_OFS_CTRL, 32'h0000_0045);
    pulse(30);
    check("in window", int_oe, 0);
endtask
task automatic t_accum();
    bus(1, CSRC_OFS_PULSES, 32'h0000_0002);
    bus(1, CSRC_OFS_CTRL, 32'h0000_0007);
    for (int i = 0; i < 3; i++)
    begin
        pulse(10);
        bus(0, CSRC_OFS_STATUS, 0);
        check("accum busy", q[1], i < 2);
    end
endtask
task automatic t_free();
    bus(1, CSRC_OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    bus(0, CSRC_OFS_RESULT + 7'h0C, 0);
    check("free result", q, IT * 4);
endtask
task automatic t_timeout();
    // Red low byte 0x0A starts with a 0, so the device holds data low
    bus(1, CSRC_OFS_CTRL, 32'h0000_0080);
    host.start();
    host.byte_io({CSRC_I2C_ADDR, 1'b1}, 1'b1, rx, ack);
    host.hold_low(10);
    check("data held", sda_oe, 1);
    host.hold_low(TO);
    check("bus freed", sda_oe, 0);
    host.stop();
endtask
////////////////////////////////////////////////////////////////
task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sync();
    t_serial();
    t_irq();
    t_accum();
    t_free();
    t_timeout();
    complete_run();
end
initial
begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
end
endmodule
